// ===== dhp_pkg.sv
// Purpose: Shared constants and types for the dual channel host bus port
// Assumes: One 200 MHz clock; host pins are asynchronous to it
// Notes:   Channel numbering follows the pick pin level (1 = A, 0 = B)
package dhp_pkg;

  localparam int unsigned DATA_W    = 8;
  localparam int unsigned IDX_W     = 3;
  localparam int unsigned NUM_REGS  = 8;
  localparam int unsigned NUM_CHANS = 2;

  // Pick pin level that selects each channel
  localparam logic CHAN_A = 1'b1;
  localparam logic CHAN_B = 1'b0;

  // Alternate function register position and its concurrent write bit
  localparam logic [IDX_W-1:0] AFR_IDX        = 3'h2;
  localparam int unsigned      AFR_CONCUR_BIT = 0;
  localparam logic [DATA_W-1:0] AFR_RESET     = 8'h00;

  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [NUM_CHANS-1:0] NO_CHANS  = 2'h0;
  localparam logic [NUM_CHANS-1:0] ALL_CHANS = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_RD_FETCH = 2'b01,
    ST_RD_HOLD  = 2'b10,
    ST_WR_HOLD  = 2'b11
  } dhp_state_t;

endpackage

// ===== dhp_store_if.sv
// Purpose: Carrier between the bus port and its register store
// Assumes: Both ends on REF_CLK
// Notes:   wr_en is indexed by channel number
`timescale 1ns/1ps
interface dhp_store_if;
  logic [dhp_pkg::NUM_CHANS-1:0] wr_en;
  logic [dhp_pkg::IDX_W-1:0]     wr_idx;
  logic [dhp_pkg::DATA_W-1:0]    wr_data;
  logic                          rd_en;
  logic                          rd_chan;
  logic [dhp_pkg::IDX_W-1:0]     rd_idx;
  logic [dhp_pkg::DATA_W-1:0]    rd_data;

  modport port  (output wr_en, wr_idx, wr_data, rd_en, rd_chan, rd_idx, input rd_data);
  modport store (input wr_en, wr_idx, wr_data, rd_en, rd_chan, rd_idx, output rd_data);
endinterface

// ===== dhp_reg_store.sv
// Purpose: Per channel register bytes behind the host port
// Assumes: Single clock, registered read data
// Notes:   One bank per channel so a concurrent write needs no second port
`timescale 1ns/1ps
module dhp_reg_store
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Access
  dhp_store_if.store bus
);

  logic [dhp_pkg::DATA_W-1:0] bank_rd [dhp_pkg::NUM_CHANS];

  genvar ch;
  generate
    for (ch = 0; ch < dhp_pkg::NUM_CHANS; ch++)
    begin : g_bank
      logic [dhp_pkg::DATA_W-1:0] mem [dhp_pkg::NUM_REGS];

      always_ff @(posedge clk)
      begin
        if (bus.wr_en[ch])
          mem[bus.wr_idx] <= bus.wr_data;
      end

      assign bank_rd[ch] = mem[bus.rd_idx];
    end
  endgenerate

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bus.rd_data <= dhp_pkg::DATA_RESET;
    else if (bus.rd_en)
      bus.rd_data <= bank_rd[bus.rd_chan];
  end

endmodule // dhp_reg_store

// ===== dhp_host_port.sv
// Purpose: Asynchronous 8-bit host bus port of a dual channel serial device
// Assumes: Host pins asynchronous to REF_CLK, strobes held low several cycles
// Notes:   Pins pass three flops; control and index levels count once stages two and three agree, write data is taken from stage three
`timescale 1ns/1ps

// How it works
// R1: Read strobe falling edge starts a read of the indexed register.
// R2: Read byte is driven on the bus until the read strobe rises.
// R3: Write strobe fall opens a write; its rise stores the bus byte.
// R4: Chip select low enables one transfer with exactly one channel, or both channels for a concurrent write.
// R5: Pick pin low addresses channel B, high addresses channel A.
// R6: Concurrent bit of alternate function register writes both channels at once.
// R7: Channel A interrupt output follows channel A service request.
// R8: Channel B interrupt output follows channel B service request.
// R9: Channel A transmit ready output is active low transmit status.
// R10: Channel B transmit ready output is active low transmit status.
// R11: Channel A receive ready output is active low receive status.
// R12: Channel B receive ready output is active low receive status.
// R13: Three bit register index selects one register of the addressed channel.
// R14: Eight bit bus is driven only during reads, sampled during writes.
// R15: With chip select high strobes are ignored and nothing changes.
module dhp_host_port
(
  // Clock and reset
  input  wire logic                          REF_CLK,
  input  wire logic                          RST,
  // Host bus pins
  input  wire logic                          CS_N,
  input  wire logic                          CHANNEL_PICK,
  input  wire logic                          READ_STROBE_N,
  input  wire logic                          WRITE_STROBE_N,
  input  wire logic [dhp_pkg::IDX_W-1:0]     REG_INDEX,
  input  wire logic [dhp_pkg::DATA_W-1:0]    DATA_IN,
  output logic      [dhp_pkg::DATA_W-1:0]    DATA_OUT,
  output logic                               DATA_OE_N,
  // Channel status from the channel cores, index 1 = A, 0 = B
  input  wire logic [dhp_pkg::NUM_CHANS-1:0] SVC_REQ,
  input  wire logic [dhp_pkg::NUM_CHANS-1:0] TX_ROOM,
  input  wire logic [dhp_pkg::NUM_CHANS-1:0] RX_AVAIL,
  // Status pins
  output logic                               IRQ_CHAN_A,
  output logic                               IRQ_CHAN_B,
  output logic                               TX_READY_CHAN_A_N,
  output logic                               TX_READY_CHAN_B_N,
  output logic                               RX_READY_CHAN_A_N,
  output logic                               RX_READY_CHAN_B_N,
  // Concurrent write mode, for the channel cores
  output logic                               CONCURRENT_WR
);

  localparam int unsigned PIN_W = 4 + dhp_pkg::IDX_W + dhp_pkg::DATA_W;

  dhp_store_if st ();

  dhp_reg_store u_store
  (
    .clk (REF_CLK),
    .rst (RST),
    .bus (st.store)
  );

  // Three stage capture of every host pin
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic [PIN_W-1:0] pin_s3_q;
  logic [PIN_W-1:0] pin_f_q;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_agree;
  localparam logic [PIN_W-1:0] PIN_RESET = {4'hf, 3'h0, 8'h00};

  assign pin_raw = {CS_N, CHANNEL_PICK, READ_STROBE_N, WRITE_STROBE_N, REG_INDEX, DATA_IN};
  assign pin_agree = ~(pin_s2_q ^ pin_s3_q);

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      pin_s1_q <= PIN_RESET;
      pin_s2_q <= PIN_RESET;
      pin_s3_q <= PIN_RESET;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Filtered level moves only where stages two and three agree
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      pin_f_q <= PIN_RESET;
    else
      pin_f_q <= (pin_s3_q & pin_agree) | (pin_f_q & ~pin_agree);
  end

  logic                          cs_n_f;
  logic                          pick_f;
  logic                          rd_n_f;
  logic                          wr_n_f;
  logic [dhp_pkg::IDX_W-1:0]     idx_f;
  logic [dhp_pkg::DATA_W-1:0]    data_f;
  logic [dhp_pkg::DATA_W-1:0]    data_next;
  logic                          rd_n_next;
  logic                          wr_n_next;

  assign {cs_n_f, pick_f, rd_n_f, wr_n_f, idx_f, data_f} = pin_f_q;
  assign rd_n_next = (pin_s3_q[PIN_W-3] & pin_agree[PIN_W-3]) | (rd_n_f & ~pin_agree[PIN_W-3]);
  assign wr_n_next = (pin_s3_q[PIN_W-4] & pin_agree[PIN_W-4]) | (wr_n_f & ~pin_agree[PIN_W-4]);
  assign data_next = pin_s3_q[dhp_pkg::DATA_W-1:0];

  // Strobe edges as seen after filtering
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;
  logic selected;

  assign rd_fall  = rd_n_f & ~rd_n_next;
  assign rd_rise  = ~rd_n_f & rd_n_next;
  assign wr_fall  = wr_n_f & ~wr_n_next;
  assign wr_rise  = ~wr_n_f & wr_n_next;
  assign selected = ~cs_n_f;

  dhp_pkg::dhp_state_t state_q;
  dhp_pkg::dhp_state_t state_d;
  logic                chan_q;
  logic [dhp_pkg::IDX_W-1:0] wr_idx_q;
  logic [dhp_pkg::DATA_W-1:0] afr_q;
  logic rd_start;
  logic wr_commit;

  // Only a selected chip sees strobes [R15]
  assign rd_start  = (state_q == dhp_pkg::ST_IDLE) && selected && rd_fall; // [R1]
  assign wr_commit = (state_q == dhp_pkg::ST_WR_HOLD) && selected && wr_rise; // [R3]

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      dhp_pkg::ST_IDLE:
      begin
        if (rd_start)
          state_d = dhp_pkg::ST_RD_FETCH; // [R1]
        else if (selected && wr_fall)
          state_d = dhp_pkg::ST_WR_HOLD; // [R3]
      end
      dhp_pkg::ST_RD_FETCH:
        state_d = dhp_pkg::ST_RD_HOLD;
      dhp_pkg::ST_RD_HOLD:
      begin
        // Early release if the host drops the chip mid cycle
        if (rd_rise || !selected)
          state_d = dhp_pkg::ST_IDLE; // [R2]
      end
      dhp_pkg::ST_WR_HOLD:
      begin
        // Deselect aborts the write, nothing is stored
        if (wr_rise || !selected)
          state_d = dhp_pkg::ST_IDLE; // [R15]
      end
      default:
        state_d = dhp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      state_q <= dhp_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // Channel and index captured at the opening strobe edge
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      chan_q   <= dhp_pkg::CHAN_A;
      wr_idx_q <= '0;
    end
    else if (state_q == dhp_pkg::ST_IDLE && selected && (rd_fall || wr_fall))
    begin
      chan_q   <= pick_f; // [R4] [R5]
      wr_idx_q <= idx_f; // [R13]
    end
  end

  // Read path into the store
  assign st.rd_en   = rd_start; // [R1]
  assign st.rd_chan = pick_f; // [R5]
  assign st.rd_idx  = idx_f; // [R13]

  // Write path: byte taken as the strobe rises; concurrent mode hits both banks
  assign st.wr_idx  = wr_idx_q;
  assign st.wr_data = data_next;
  always_comb
  begin
    st.wr_en = dhp_pkg::NO_CHANS;
    if (wr_commit)
    begin
      if (afr_q[dhp_pkg::AFR_CONCUR_BIT])
        st.wr_en = dhp_pkg::ALL_CHANS; // [R6]
      else
        st.wr_en[chan_q] = 1'b1; // [R4] [R5]
    end
  end

  // Shadow of the alternate function byte so the mode bit steers writes
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      afr_q <= dhp_pkg::AFR_RESET;
    else if (wr_commit && wr_idx_q == dhp_pkg::AFR_IDX)
      afr_q <= data_next; // [R6]
  end

  assign CONCURRENT_WR = afr_q[dhp_pkg::AFR_CONCUR_BIT];

  // Bus drive: only from fetched data until the strobe releases
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      DATA_OUT  <= dhp_pkg::DATA_RESET;
      DATA_OE_N <= 1'b1;
    end
    else if (state_q == dhp_pkg::ST_RD_FETCH)
    begin
      DATA_OUT  <= st.rd_data; // [R2]
      DATA_OE_N <= 1'b0; // [R14]
    end
    else if (state_q == dhp_pkg::ST_RD_HOLD && (rd_rise || !selected))
      DATA_OE_N <= 1'b1; // [R14] [R15]
  end

  // Core status is same clock domain, registered straight to the pins
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      IRQ_CHAN_A        <= 1'b0;
      IRQ_CHAN_B        <= 1'b0;
      TX_READY_CHAN_A_N <= 1'b1;
      TX_READY_CHAN_B_N <= 1'b1;
      RX_READY_CHAN_A_N <= 1'b1;
      RX_READY_CHAN_B_N <= 1'b1;
    end
    else
    begin
      IRQ_CHAN_A        <= SVC_REQ[dhp_pkg::CHAN_A]; // [R7]
      IRQ_CHAN_B        <= SVC_REQ[dhp_pkg::CHAN_B]; // [R8]
      TX_READY_CHAN_A_N <= ~TX_ROOM[dhp_pkg::CHAN_A]; // [R9]
      TX_READY_CHAN_B_N <= ~TX_ROOM[dhp_pkg::CHAN_B]; // [R10]
      RX_READY_CHAN_A_N <= ~RX_AVAIL[dhp_pkg::CHAN_A]; // [R11]
      RX_READY_CHAN_B_N <= ~RX_AVAIL[dhp_pkg::CHAN_B]; // [R12]
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  AST_RD_START: assert property (rd_start |=> state_q == dhp_pkg::ST_RD_FETCH) // [R1]
    else $error("read strobe fall did not start a fetch");
  AST_RD_DRIVE: assert property (rd_start |-> ##2 (!DATA_OE_N && DATA_OUT == $past(st.rd_data))) // [R2]
    else $error("read byte not driven two cycles after strobe fall");
  AST_WR_COMMIT: assert property (wr_commit |-> st.wr_en != dhp_pkg::NO_CHANS) // [R3]
    else $error("write strobe rise stored nothing");
  AST_ONE_CHAN: assert property ((|st.wr_en && !CONCURRENT_WR) |-> ($onehot(st.wr_en) && st.wr_en[chan_q])) // [R4]
    else $error("normal write did not hit exactly the picked channel");
  AST_PICK: assert property ((state_q == dhp_pkg::ST_IDLE && selected && wr_fall) |=> chan_q == $past(pick_f)) // [R5]
    else $error("channel not taken from pick level");
  AST_BOTH: assert property ((|st.wr_en && CONCURRENT_WR) |-> st.wr_en == dhp_pkg::ALL_CHANS) // [R6]
    else $error("concurrent write missed a channel");
  AST_IRQ: assert property (##1 (IRQ_CHAN_A == $past(SVC_REQ[1]) && IRQ_CHAN_B == $past(SVC_REQ[0]))) // [R7]
    else $error("interrupt pins do not follow requests");
  AST_READY: assert property (##1 (TX_READY_CHAN_B_N != $past(TX_ROOM[0]) && RX_READY_CHAN_A_N != $past(RX_AVAIL[1]))) // [R10]
    else $error("ready pins not active low status");
  AST_NO_DRIVE: assert property ((state_q != dhp_pkg::ST_RD_HOLD) |=> DATA_OE_N || $past(state_q == dhp_pkg::ST_RD_FETCH)) // [R14]
    else $error("bus driven outside a read");
  AST_CS_IGNORE: assert property (cs_n_f |-> (!st.rd_en && st.wr_en == dhp_pkg::NO_CHANS)) // [R15]
    else $error("access while chip deselected");
  AST_CUT_REL: assert property ((state_q == dhp_pkg::ST_RD_HOLD && !selected) |=> DATA_OE_N) // [R15]
    else $error("bus still driven after deselect in a read");

  COV_READ: cover property (rd_start ##2 !DATA_OE_N);
  COV_WRITE: cover property (wr_commit && !CONCURRENT_WR);
  COV_CONCUR: cover property (wr_commit && CONCURRENT_WR);
  COV_CUT: cover property (state_q == dhp_pkg::ST_WR_HOLD && !selected);

endmodule // dhp_host_port

// ===== dhp_host_model.sv
// Purpose: Host processor model for the asynchronous byte bus
// Assumes: Host pins change at the falling clock edge, except the undriven bus, which toggles at the rising edge
// Notes:   A floating bus shows a changing pattern, never a held byte
`timescale 1ns/1ps
module dhp_host_model
(
  // Clock
  input  wire logic       clk,
  // Device side of the bus
  input  wire logic [7:0] dout,
  input  wire logic       oe_n,
  // Host pins
  output logic            cs_n,
  output logic            pick,
  output logic            rd_n,
  output logic            wr_n,
  output logic [2:0]      idx,
  output logic [7:0]      din
);
  logic       drv = 1'b0;
  logic [7:0] hv = 8'h00;
  logic [7:0] last_q = 8'h00;

  // Undriven wire toggles so a stale byte cannot pass for a read
  assign din = !oe_n ? dout : (drv ? hv : ~last_q);
  always @(posedge clk) last_q <= din;

  initial
  begin
    cs_n = 1'b1;
    pick = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    idx  = 3'h0;
  end

  task automatic xfer(input logic rd, input logic cs, input logic ch, input logic [2:0] i,
                      input logic [7:0] d, input logic cut, output logic [7:0] q, output logic seen);
    seen = 1'b0;
    @(negedge clk);
    cs_n = cs;
    pick = ch;
    idx  = i;
    hv   = d;
    drv  = !rd;
    repeat (4) @(negedge clk);
    rd_n = !rd;
    wr_n = rd;
    for (int k = 0; k < 12; k++)
    begin
      @(negedge clk);
      seen = seen | !oe_n;
      // Cut transfer drops the chip four cycles into the strobe
      if (cut && k == 3)
        cs_n = 1'b1;
    end
    q    = din;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    drv  = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule // dhp_host_model

// ===== dual_channel_host_bus_port_bench.sv
// Purpose: Self-checking bench for the dual channel host bus port
// Assumes: Host model paces strobes per the port's timing contract
// Notes:   Store holds no reset value, so only written bytes are read
`timescale 1ns/1ps
module dual_channel_host_bus_port_bench;
  localparam logic A = dhp_pkg::CHAN_A;
  localparam logic B = dhp_pkg::CHAN_B;
  logic       ref_clk = 1'b0;
  logic       rst     = 1'b1;
  logic       cs_n;
  logic       pick;
  logic       rd_n;
  logic       wr_n;
  logic [2:0] idx;
  logic [7:0] din;
  logic [7:0] dout;
  logic       oe_n;
  logic [1:0] svc      = 2'h0;
  logic [1:0] tx_room  = 2'h0;
  logic [1:0] rx_avail = 2'h0;
  logic       irq_a;
  logic       irq_b;
  logic       txa_n;
  logic       txb_n;
  logic       rxa_n;
  logic       rxb_n;
  logic       conc;
  int         n_mismatch = 0;
  int         num_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  dhp_host_port uut (.REF_CLK(ref_clk), .RST(rst), .CS_N(cs_n), .CHANNEL_PICK(pick), .READ_STROBE_N(rd_n),
    .WRITE_STROBE_N(wr_n), .REG_INDEX(idx), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(oe_n), .SVC_REQ(svc),
    .TX_ROOM(tx_room), .RX_AVAIL(rx_avail), .IRQ_CHAN_A(irq_a), .IRQ_CHAN_B(irq_b), .TX_READY_CHAN_A_N(txa_n),
    .TX_READY_CHAN_B_N(txb_n), .RX_READY_CHAN_A_N(rxa_n), .RX_READY_CHAN_B_N(rxb_n), .CONCURRENT_WR(conc));

  dhp_host_model host (.clk(ref_clk), .dout(dout), .oe_n(oe_n), .cs_n(cs_n), .pick(pick), .rd_n(rd_n),
    .wr_n(wr_n), .idx(idx), .din(din));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic cs, input logic ch, input logic [2:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic       seen;
    host.xfer(1'b0, cs, ch, i, d, 1'b0, q, seen);
    chk(8'(seen), 8'h00);
  endtask

  // A deselected read must never open the bus
  task automatic rd(input logic cs, input logic ch, input logic [2:0] i, input logic [7:0] exp);
    logic [7:0] q;
    logic       seen;
    host.xfer(1'b1, cs, ch, i, 8'h00, 1'b0, q, seen);
    chk(8'(seen), 8'(!cs));
    if (!cs)
      chk(q, exp);
  endtask

  task automatic t_reset();
    chk(8'({oe_n, irq_a, irq_b, txa_n, txb_n, rxa_n, rxb_n, conc}), 8'h9e);
    chk(dout, dhp_pkg::DATA_RESET);
  endtask

  // Same index in both channels keeps the banks apart
  task automatic t_chan();
    wr(1'b0, A, 3'h1, 8'ha5);
    wr(1'b0, B, 3'h1, 8'h3c);
    wr(1'b0, A, 3'h7, 8'hf0);
    wr(1'b0, B, 3'h0, 8'h0f);
    rd(1'b0, A, 3'h1, 8'ha5);
    rd(1'b0, B, 3'h1, 8'h3c);
    rd(1'b0, A, 3'h7, 8'hf0);
    rd(1'b0, B, 3'h0, 8'h0f);
  endtask

  task automatic t_desel();
    wr(1'b1, A, 3'h1, 8'h5a);
    rd(1'b1, A, 3'h1, 8'h00);
    rd(1'b0, A, 3'h1, 8'ha5);
  endtask

  // Chip dropped mid strobe: the write is lost, the read lets go of the bus
  task automatic t_cut();
    logic [7:0] q;
    logic       seen;
    host.xfer(1'b0, 1'b0, A, 3'h1, 8'h66, 1'b1, q, seen);
    chk(8'(seen), 8'h00);
    rd(1'b0, A, 3'h1, 8'ha5);
    host.xfer(1'b1, 1'b0, B, 3'h1, 8'h00, 1'b1, q, seen);
    chk(8'({seen, oe_n}), 8'h03);
    rd(1'b0, B, 3'h1, 8'h3c);
  endtask

  task automatic t_conc();
    wr(1'b0, A, dhp_pkg::AFR_IDX, 8'h01);
    chk(8'(conc), 8'h01);
    wr(1'b0, A, 3'h5, 8'hc3);
    rd(1'b0, B, 3'h5, 8'hc3);
    rd(1'b0, A, 3'h5, 8'hc3);
    wr(1'b0, B, dhp_pkg::AFR_IDX, 8'h00);
    chk(8'(conc), 8'h00);
    wr(1'b0, A, 3'h5, 8'h77);
    rd(1'b0, B, 3'h5, 8'hc3);
  endtask

  task automatic t_stat();
    for (int v = 0; v < 4; v++)
    begin
      svc      = 2'(v);
      tx_room  = 2'(v);
      rx_avail = ~2'(v);
      repeat (2) @(negedge ref_clk);
      chk(8'({irq_a, irq_b, txa_n, txb_n, rxa_n, rxb_n}), 8'({svc, ~tx_room, ~rx_avail}));
    end
  endtask

  initial
  begin
    repeat (2) @(negedge ref_clk);
    t_reset();
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_chan();
    t_desel();
    t_cut();
    t_conc();
    t_stat();
    finish_test();
  end

  initial
  begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule // dual_channel_host_bus_port_bench
